//--- inc/ocf_pkg.sv
package ocf_pkg;

   // Register offsets on the register port
   localparam logic [7:0] OCF_ADDR_INPUT_CONFIG = 8'h09;
   localparam logic [7:0] OCF_ADDR_DIFF_IO_CONFIG = 8'h0a;
   localparam logic [7:0] OCF_ADDR_MON_SW_BO_CONFIG = 8'h0b;
   localparam logic [7:0] OCF_ADDR_IRQ_PIN_CONFIG = 8'h0c;
   localparam logic [7:0] OCF_ADDR_IRQ_STATUS_G3 = 8'h0f;
   localparam logic [7:0] OCF_ADDR_IRQ_ENABLE_G3 = 8'h12;
   localparam logic [7:0] OCF_ADDR_OPERATING_STATE = 8'h52;
   localparam logic [7:0] OCF_ADDR_CLKOUT_B_FREQ = 8'h6d;
   localparam logic [7:0] OCF_ADDR_CLKOUT_A_FREQ = 8'h71;
   localparam logic [7:0] OCF_ADDR_CLKOUT_B_INV = 8'h72;
   localparam logic [7:0] OCF_ADDR_CLKOUT_A_INV = 8'h73;
   localparam logic [7:0] OCF_ADDR_FRAME_SYNC_OUT = 8'h74;
   localparam logic [7:0] OCF_ADDR_SYNC_MONITOR = 8'h7c;
   localparam logic [7:0] OCF_ADDR_SYNC_PHASE = 8'h7d;

   // Reset value of every configuration register
   localparam logic [7:0] OCF_CFG_RESET = 8'h00;

   // Field positions
   localparam int OCF_BIT_SYNC_LOCK_EN = 0;
   localparam int OCF_BIT_AUTO_SYNC_LOCK_EN = 1;
   localparam int OCF_BIT_REF_FAIL_ON_SCAN = 0;
   localparam int OCF_BIT_IRQ_POLARITY = 0;
   localparam int OCF_BIT_IRQ_TRISTATE = 1;
   localparam int OCF_BIT_EV_REF_VALID = 0;
   localparam int OCF_BIT_EV_REF_FAIL = 1;
   localparam int OCF_BIT_EV_MODE = 2;
   localparam int OCF_BIT_EV_SYNC_ALARM = 3;
   localparam int OCF_BIT_ALARM_LIVE = 7;
   localparam int OCF_BIT_CLKOUT_INVERT = 0;
   localparam int OCF_BIT_FS8_EN = 7;
   localparam int OCF_BIT_FS2_EN = 6;
   localparam int OCF_BIT_FS8_INV = 5;
   localparam int OCF_BIT_FS2_INV = 4;
   localparam int OCF_BIT_FS8_PUL = 3;
   localparam int OCF_BIT_FS2_PUL = 2;
   localparam int OCF_BIT_PUL_EDGE = 1;
   localparam int OCF_BIT_SYNC_BYPASS = 7;

   // Clock source select codes
   localparam logic [3:0] OCF_SRC_DPLL_77M = 4'h0;
   localparam logic [3:0] OCF_SRC_DPLL_16E1 = 4'h1;
   localparam logic [3:0] OCF_SRC_DPLL_GSM = 4'h2;
   localparam logic [3:0] OCF_SRC_DPLL_E3 = 4'h3;
   localparam logic [3:0] OCF_SRC_APLL_MAIN = 4'h4;
   localparam logic [3:0] OCF_SRC_APLL_AUX = 4'h5;

   // Divider codes with fixed meaning
   localparam logic [3:0] OCF_DIV_OFF_LOW = 4'h0;
   localparam logic [3:0] OCF_DIV_OFF_HIGH = 4'hf;

   // Reference selection codes
   localparam logic [1:0] OCF_REF_NONE = 2'h0;
   localparam logic [1:0] OCF_REF_A = 2'h1;
   localparam logic [1:0] OCF_REF_B = 2'h2;
   localparam logic [1:0] OCF_REF_C = 2'h3;

   // Sample phase codes and the edge delay each selects
   localparam logic [1:0] OCF_SPH_NOMINAL = 2'h0;
   localparam logic [1:0] OCF_SPH_HALF_EARLY = 2'h1;
   localparam logic [1:0] OCF_SPH_HALF_LATE = 2'h2;
   localparam logic [1:0] OCF_SPH_ONE_LATE = 2'h3;

   // Timing
   localparam int OCF_CLK_PERIOD_NS = 10;
   localparam int OCF_FRAME_PERIOD_US = 125;
   localparam int OCF_FRAME_CYCLES =
      (OCF_FRAME_PERIOD_US * 1000) / OCF_CLK_PERIOD_NS;
   localparam int OCF_FS8_HALF_TICKS = 77760;
   localparam int OCF_LIMIT_UNIT_CYCLES = 1;

   // Source edges per output half period; zero marks reserved
   function automatic logic [26:0] ocf_ratio(input logic [3:0] src,
                                             input logic [3:0] code,
                                             input logic is_b);
      logic [26:0] r;
      r = 27'd0;
      case (src)
         OCF_SRC_DPLL_77M: begin
            case (code)
               4'ha: r = 27'd1215;
               4'hb: r = 27'd9720;
               4'hc: r = 27'd38880;
               4'hd: r = 27'd194400;
               4'he: r = 27'd77760000;
               default: r = 27'd0;
            endcase
         end
         OCF_SRC_DPLL_16E1: begin
            case (code)
               4'h2: r = 27'd1;
               4'h3: r = 27'd2;
               4'h4: r = 27'd4;
               4'h6: r = 27'd8;
               4'h8: r = 27'd16;
               default: r = 27'd0;
            endcase
         end
         OCF_SRC_DPLL_GSM: begin
            case (code)
               4'h2: r = 27'd1;
               4'h3: r = 27'd2;
               default: r = 27'd0;
            endcase
         end
         OCF_SRC_DPLL_E3: r = (code == 4'h2) ? 27'd1 : 27'd0;
         OCF_SRC_APLL_MAIN, OCF_SRC_APLL_AUX: begin
            case (code)
               4'h1: r = is_b ? 27'd0 : 27'd1;
               4'h2: r = is_b ? 27'd0 : 27'd2;
               4'h3: r = 27'd4;
               4'h4: r = 27'd8;
               4'h5: r = 27'd12;
               4'h6: r = 27'd16;
               4'h7: r = 27'd24;
               4'h8: r = 27'd32;
               4'h9: r = 27'd5;
               4'ha: r = 27'd10;
               4'hb: r = 27'd96;
               4'hc: r = 27'd40;
               4'hd: r = 27'd80;
               default: r = 27'd0;
            endcase
            if (src == OCF_SRC_APLL_AUX && (code == 4'h9 || code == 4'ha ||
                code == 4'hc || code == 4'hd)) begin
               r = 27'd0;
            end
         end
         default: r = 27'd0;
      endcase
      return r;
   endfunction : ocf_ratio

endpackage : ocf_pkg

//--- rtl/ocf_top.sv
`timescale 1ns/100ps
module ocf_top
   import ocf_pkg::*;
#(
   parameter int FRAME_CYCLES = OCF_FRAME_CYCLES,
   parameter int FS8_HALF_TICKS = OCF_FS8_HALF_TICKS,
   parameter int LIMIT_UNIT_CYCLES = OCF_LIMIT_UNIT_CYCLES
)(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [3:0] dpll_tick,
   input wire logic apll_main_tick,
   input wire logic apll_aux_tick,
   input wire logic [1:0] ref_select,
   input wire logic [2:0] loop_mode,
   input wire logic ev_ref_valid_change,
   input wire logic ev_ref_fail,
   input wire logic ev_mode_change,
   input wire logic ext_frame_in_a,
   input wire logic ext_frame_in_b,
   input wire logic ext_frame_in_c,
   input wire logic scan_data_in,
   output logic clkout_a,
   output logic clkout_b,
   output logic clkout_a_lvds_select,
   output logic frame_sync_pin,
   output logic frame_sync_pin_oe,
   output logic multiframe_sync_pin,
   output logic multiframe_sync_pin_oe,
   output logic irq_pin,
   output logic irq_pin_oe,
   output logic scan_out
);

   logic [7:0] input_config_q;
   logic [7:0] diff_io_config_q;
   logic [7:0] mon_sw_bo_config_q;
   logic [7:0] irq_pin_config_q;
   logic [7:0] irq_enable_q;
   logic [7:0] clkout_a_freq_q;
   logic [7:0] clkout_b_freq_q;
   logic [7:0] clkout_a_inv_q;
   logic [7:0] clkout_b_inv_q;
   logic [7:0] frame_sync_out_q;
   logic [7:0] sync_monitor_q;
   logic [7:0] sync_phase_q;
   logic [3:0] irq_status_q;
   logic [3:0] irq_status_d;
   logic [3:0] irq_event;
   logic irq_clear_wr;

   // Configuration register writes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         input_config_q <= OCF_CFG_RESET;
         diff_io_config_q <= OCF_CFG_RESET;
         mon_sw_bo_config_q <= OCF_CFG_RESET;
         irq_pin_config_q <= OCF_CFG_RESET;
         irq_enable_q <= OCF_CFG_RESET;
         clkout_a_freq_q <= OCF_CFG_RESET;
         clkout_b_freq_q <= OCF_CFG_RESET;
         clkout_a_inv_q <= OCF_CFG_RESET;
         clkout_b_inv_q <= OCF_CFG_RESET;
         frame_sync_out_q <= OCF_CFG_RESET;
         sync_monitor_q <= OCF_CFG_RESET;
         sync_phase_q <= OCF_CFG_RESET;
      end else if (reg_wr) begin
         if (reg_addr == OCF_ADDR_INPUT_CONFIG) begin
            input_config_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_DIFF_IO_CONFIG) begin
            diff_io_config_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_MON_SW_BO_CONFIG) begin
            mon_sw_bo_config_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_IRQ_PIN_CONFIG) begin
            irq_pin_config_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_IRQ_ENABLE_G3) begin
            irq_enable_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_CLKOUT_B_FREQ) begin
            clkout_b_freq_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_CLKOUT_A_FREQ) begin
            clkout_a_freq_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_CLKOUT_B_INV) begin
            clkout_b_inv_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_CLKOUT_A_INV) begin
            clkout_a_inv_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_FRAME_SYNC_OUT) begin
            frame_sync_out_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_SYNC_MONITOR) begin
            sync_monitor_q <= reg_wdata;
         end else if (reg_addr == OCF_ADDR_SYNC_PHASE) begin
            sync_phase_q <= reg_wdata;
         end
      end
   end

   logic alarm_q;

   // Read data, registered; unmapped addresses read zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == OCF_ADDR_INPUT_CONFIG) begin
            reg_rdata <= input_config_q;
         end else if (reg_addr == OCF_ADDR_DIFF_IO_CONFIG) begin
            reg_rdata <= diff_io_config_q;
         end else if (reg_addr == OCF_ADDR_MON_SW_BO_CONFIG) begin
            reg_rdata <= mon_sw_bo_config_q;
         end else if (reg_addr == OCF_ADDR_IRQ_PIN_CONFIG) begin
            reg_rdata <= irq_pin_config_q;
         end else if (reg_addr == OCF_ADDR_IRQ_STATUS_G3) begin
            reg_rdata <= {4'h0, irq_status_q};
         end else if (reg_addr == OCF_ADDR_IRQ_ENABLE_G3) begin
            reg_rdata <= irq_enable_q;
         end else if (reg_addr == OCF_ADDR_OPERATING_STATE) begin
            reg_rdata <= {alarm_q, 4'h0, loop_mode};
         end else if (reg_addr == OCF_ADDR_CLKOUT_B_FREQ) begin
            reg_rdata <= clkout_b_freq_q;
         end else if (reg_addr == OCF_ADDR_CLKOUT_A_FREQ) begin
            reg_rdata <= clkout_a_freq_q;
         end else if (reg_addr == OCF_ADDR_CLKOUT_B_INV) begin
            reg_rdata <= clkout_b_inv_q;
         end else if (reg_addr == OCF_ADDR_CLKOUT_A_INV) begin
            reg_rdata <= clkout_a_inv_q;
         end else if (reg_addr == OCF_ADDR_FRAME_SYNC_OUT) begin
            reg_rdata <= frame_sync_out_q;
         end else if (reg_addr == OCF_ADDR_SYNC_MONITOR) begin
            reg_rdata <= sync_monitor_q;
         end else if (reg_addr == OCF_ADDR_SYNC_PHASE) begin
            reg_rdata <= sync_phase_q;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // Frame period timer for main-path realignment
   logic [31:0] frame_cnt_q;
   logic frame_tick;
   assign frame_tick = (frame_cnt_q == 32'(FRAME_CYCLES - 1));
   always_ff @(posedge clock) begin
      if (sys_rst || frame_tick) begin
         frame_cnt_q <= 32'h0;
      end else begin
         frame_cnt_q <= frame_cnt_q + 32'h1;
      end
   end

   // Clock output dividers, one per output
   logic [5:0] src_ticks;
   logic [1:0] clk_lvl;
   logic [1:0] clk_out_q;
   assign src_ticks = {apll_aux_tick, apll_main_tick, dpll_tick};

   for (genvar g = 0; g < 2; g++) begin : g_clkout
      logic [3:0] sel;
      logic [3:0] code;
      logic inv;
      logic [26:0] ratio;
      logic [26:0] cnt_q;
      logic lvl_q;
      logic out_q;
      logic tick;
      logic main_path;
      assign sel = (g == 0) ? clkout_a_freq_q[7:4] : clkout_b_freq_q[7:4];
      assign code = (g == 0) ? clkout_a_freq_q[3:0] : clkout_b_freq_q[3:0];
      assign inv = (g == 0) ? clkout_a_inv_q[OCF_BIT_CLKOUT_INVERT] :
                              clkout_b_inv_q[OCF_BIT_CLKOUT_INVERT];
      // Reserved, output-A-only and OBSAI-on-aux codes give zero
      assign ratio = ocf_ratio(sel, code, (g == 1));
      assign tick = (sel <= OCF_SRC_APLL_AUX) ? src_ticks[sel[2:0]] : 1'b0;
      assign main_path = (sel <= OCF_SRC_APLL_MAIN);

      // Edge counter; toggles every ratio source edges
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            cnt_q <= 27'h0;
            lvl_q <= 1'b0;
         end else if (frame_tick && main_path) begin
            cnt_q <= 27'h0;
            lvl_q <= 1'b0;
         end else if (tick && ratio != 27'h0) begin
            if (cnt_q >= ratio - 27'h1) begin
               cnt_q <= 27'h0;
               lvl_q <= ~lvl_q;
            end else begin
               cnt_q <= cnt_q + 27'h1;
            end
         end
      end

      // Output level with disable codes and inversion
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            out_q <= 1'b0;
         end else if (code == OCF_DIV_OFF_LOW) begin
            out_q <= 1'b0;
         end else if (code == OCF_DIV_OFF_HIGH) begin
            out_q <= 1'b1;
         end else if (ratio == 27'h0) begin
            out_q <= 1'b0;
         end else begin
            out_q <= lvl_q ^ inv;
         end
      end
      assign clk_out_q[g] = out_q;
      assign clk_lvl[g] = lvl_q;
   end

   assign clkout_a = clk_out_q[0];
   assign clkout_b = clk_out_q[1];
   assign clkout_a_lvds_select = diff_io_config_q[0];

   // Two-flop synchronisers for the external frame inputs
   logic [2:0] ext_meta_q;
   logic [2:0] ext_sync_q;
   logic [2:0] ext_prev_q;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ext_meta_q <= 3'h0;
         ext_sync_q <= 3'h0;
         ext_prev_q <= 3'h0;
      end else begin
         ext_meta_q <= {ext_frame_in_c, ext_frame_in_b, ext_frame_in_a};
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   // Input selection by bypass bit and chosen reference
   logic bypass;
   logic [1:0] sel_in;
   logic sel_fall;
   logic [1:0] sel_phase;
   assign bypass = sync_monitor_q[OCF_BIT_SYNC_BYPASS];
   always_comb begin
      sel_in = OCF_REF_A;
      if (bypass) begin
         sel_in = ref_select;
      end
      sel_fall = 1'b0;
      sel_phase = sync_phase_q[1:0];
      if (sel_in == OCF_REF_A) begin
         sel_fall = ext_prev_q[0] & ~ext_sync_q[0];
         sel_phase = sync_phase_q[1:0];
      end else if (sel_in == OCF_REF_B) begin
         sel_fall = ext_prev_q[1] & ~ext_sync_q[1];
         sel_phase = sync_phase_q[3:2];
      end else if (sel_in == OCF_REF_C) begin
         sel_fall = ext_prev_q[2] & ~ext_sync_q[2];
         sel_phase = sync_phase_q[5:4];
      end
   end

   // Sampling-phase compensation by delaying the edge
   logic [3:0] fall_dly_q;
   logic ext_edge;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fall_dly_q <= 4'h0;
      end else begin
         fall_dly_q <= {fall_dly_q[2:0], sel_fall};
      end
   end
   always_comb begin
      case (sel_phase)
         OCF_SPH_HALF_EARLY: ext_edge = fall_dly_q[3];
         OCF_SPH_NOMINAL: ext_edge = fall_dly_q[2];
         OCF_SPH_HALF_LATE: ext_edge = fall_dly_q[1];
         OCF_SPH_ONE_LATE: ext_edge = fall_dly_q[0];
         default: ext_edge = fall_dly_q[2];
      endcase
   end

   // Synchronisation control
   logic lock_en;
   logic auto_en;
   logic sync_allowed;
   logic resync;
   assign lock_en = input_config_q[OCF_BIT_SYNC_LOCK_EN];
   assign auto_en = input_config_q[OCF_BIT_AUTO_SYNC_LOCK_EN];
   assign sync_allowed = bypass | (lock_en & ~auto_en);

   // Phase monitor: cycles from last frame boundary
   logic [15:0] since_q;
   logic [15:0] limit_cycles;
   logic fs_boundary;
   logic over_limit;
   assign limit_cycles = 16'(sync_monitor_q[2:0] * LIMIT_UNIT_CYCLES);
   assign over_limit = (since_q > limit_cycles);
   always_ff @(posedge clock) begin
      if (sys_rst || fs_boundary) begin
         since_q <= 16'h0;
      end else if (since_q != 16'hffff) begin
         since_q <= since_q + 16'h1;
      end
   end

   // Alarm follows each measured edge; clears when back within limit
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         alarm_q <= 1'b0;
      end else if (ext_edge) begin
         alarm_q <= over_limit;
      end
   end
   assign resync = ext_edge & sync_allowed & ~over_limit & ~alarm_q;

   // Frame sync square waves from main analog loop edges
   logic [26:0] fs_cnt_q;
   logic fs8_q;
   logic fs2_q;
   logic [1:0] fs_quart_q;
   logic fs8_toggle;
   assign fs8_toggle = apll_main_tick &&
                       (fs_cnt_q >= 27'(FS8_HALF_TICKS - 1));
   assign fs_boundary = resync | (fs8_toggle & ~fs8_q);
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fs_cnt_q <= 27'h0;
         fs8_q <= 1'b0;
         fs2_q <= 1'b0;
         fs_quart_q <= 2'h0;
      end else if (resync) begin
         fs_cnt_q <= 27'h0;
         fs8_q <= 1'b1;
         fs2_q <= 1'b1;
         fs_quart_q <= 2'h1;
      end else if (apll_main_tick) begin
         if (fs8_toggle) begin
            fs_cnt_q <= 27'h0;
            fs8_q <= ~fs8_q;
            fs_quart_q <= fs_quart_q + 2'h1;
            if (fs_quart_q == 2'h3) begin
               fs2_q <= ~fs2_q;
            end
         end else begin
            fs_cnt_q <= fs_cnt_q + 27'h1;
         end
      end
   end

   // Pulsed mode: set at chosen square edge, held until next output-B divider level rise
   logic fs8_prev_q;
   logic fs2_prev_q;
   logic clkb_prev_q;
   logic pul8_q;
   logic pul2_q;
   logic edge_rise;
   logic clkb_rise;
   logic edge8;
   logic edge2;
   assign edge_rise = frame_sync_out_q[OCF_BIT_PUL_EDGE];
   assign clkb_rise = clk_lvl[1] & ~clkb_prev_q;
   assign edge8 = edge_rise ? (fs8_q & ~fs8_prev_q) : (~fs8_q & fs8_prev_q);
   assign edge2 = edge_rise ? (fs2_q & ~fs2_prev_q) : (~fs2_q & fs2_prev_q);
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fs8_prev_q <= 1'b0;
         fs2_prev_q <= 1'b0;
         clkb_prev_q <= 1'b0;
         pul8_q <= 1'b0;
         pul2_q <= 1'b0;
      end else begin
         fs8_prev_q <= fs8_q;
         fs2_prev_q <= fs2_q;
         clkb_prev_q <= clk_lvl[1];
         if (edge8) begin
            pul8_q <= 1'b1;
         end else if (clkb_rise) begin
            pul8_q <= 1'b0;
         end
         if (edge2) begin
            pul2_q <= 1'b1;
         end else if (clkb_rise) begin
            pul2_q <= 1'b0;
         end
      end
   end

   // Frame sync pins: shape, inversion and enable
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         frame_sync_pin <= 1'b0;
         multiframe_sync_pin <= 1'b0;
         frame_sync_pin_oe <= 1'b0;
         multiframe_sync_pin_oe <= 1'b0;
      end else begin
         frame_sync_pin <= (frame_sync_out_q[OCF_BIT_FS8_PUL] ? pul8_q : fs8_q)
                           ^ frame_sync_out_q[OCF_BIT_FS8_INV];
         multiframe_sync_pin <=
            (frame_sync_out_q[OCF_BIT_FS2_PUL] ? pul2_q : fs2_q)
            ^ frame_sync_out_q[OCF_BIT_FS2_INV];
         frame_sync_pin_oe <= frame_sync_out_q[OCF_BIT_FS8_EN];
         multiframe_sync_pin_oe <= frame_sync_out_q[OCF_BIT_FS2_EN];
      end
   end

   // Interrupt status: set wins over write-one clear
   logic alarm_prev_q;
   assign irq_clear_wr = reg_wr && (reg_addr == OCF_ADDR_IRQ_STATUS_G3);
   assign irq_event = {alarm_q & ~alarm_prev_q, ev_mode_change,
                       ev_ref_fail, ev_ref_valid_change};
   always_comb begin
      irq_status_d = irq_status_q;
      if (irq_clear_wr) begin
         irq_status_d = irq_status_d & ~reg_wdata[3:0];
      end
      irq_status_d = irq_status_d | irq_event;
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_status_q <= 4'h0;
         alarm_prev_q <= 1'b0;
      end else begin
         irq_status_q <= irq_status_d;
         alarm_prev_q <= alarm_q;
      end
   end

   // Request pin and scan output
   logic irq_active;
   assign irq_active = |(irq_status_q & irq_enable_q[3:0]);
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_pin <= 1'b0;
         irq_pin_oe <= 1'b0;
         scan_out <= 1'b0;
      end else begin
         irq_pin <= irq_pin_config_q[OCF_BIT_IRQ_POLARITY] ?
                    irq_active : ~irq_active;
         irq_pin_oe <= irq_pin_config_q[OCF_BIT_IRQ_TRISTATE] ?
                       irq_active : 1'b1;
         scan_out <= mon_sw_bo_config_q[OCF_BIT_REF_FAIL_ON_SCAN] ?
                     irq_status_q[OCF_BIT_EV_REF_FAIL] : scan_data_in;
      end
   end

endmodule : ocf_top

//--- verification/ocf_top_sva.sv
`timescale 1ns/100ps
module ocf_top_sva
   import ocf_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic ev_ref_fail,
   input wire logic clkout_a,
   input wire logic clkout_b,
   input wire logic frame_sync_pin_oe,
   input wire logic irq_pin,
   input wire logic irq_pin_oe,
   input wire logic scan_out
);
   logic [7:0] sh_q [256];
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Shadow of each register write
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < 256; i++) sh_q[i] <= OCF_CFG_RESET;
      end else if (reg_wr) begin
         sh_q[reg_addr] <= reg_wdata;
      end
   end
   property p_oe; !sh_q[8'h74][7] [*3] |-> !frame_sync_pin_oe; endproperty
   a_oe: assert property (p_oe) else $error("sync pin driven");
   property p_on; sh_q[8'h74][7] [*3] |-> frame_sync_pin_oe; endproperty
   a_on: assert property (p_on) else $error("sync pin idle");
   property p_lo; (sh_q[8'h71] inside {8'h00, 8'h59}) [*3] |-> !clkout_a;
   endproperty
   a_lo: assert property (p_lo) else $error("clock a not low");
   property p_hi; (sh_q[8'h71][3:0] == OCF_DIV_OFF_HIGH) [*3] |-> clkout_a;
   endproperty
   a_hi: assert property (p_hi) else $error("clock a not high");
   property p_b; (sh_q[8'h6d] == 8'h41) [*3] |-> !clkout_b; endproperty
   a_b: assert property (p_b) else $error("clock b fast rate");
   // Enabled event, active low driven pin two edges later
   property p_irq; ev_ref_fail && sh_q[8'h12][1] && sh_q[8'h0c][1:0] == 2'h0
      |=> ##1 !irq_pin && irq_pin_oe; endproperty
   a_irq: assert property (p_irq) else $error("no request");
   property p_tri; (sh_q[8'h0c] == 8'h02) [*3] ##0 irq_pin_oe |-> !irq_pin;
   endproperty
   a_tri: assert property (p_tri) else $error("bad drive");
   property p_scan; sh_q[8'h0b][0] [*2] ##0 ev_ref_fail |=> ##1 scan_out;
   endproperty
   a_scan: assert property (p_scan) else $error("scan out low");
endmodule : ocf_top_sva
bind ocf_top ocf_top_sva i_sva (.*);

//--- verification/ocf_clk_sink.sv
`timescale 1ns/100ps
module ocf_clk_sink (
   input wire logic clk_in,
   output int period_ns
);
   realtime last_t = 0;
   // Time between rising edges of the received clock
   always @(posedge clk_in) begin
      period_ns = int'($realtime - last_t);
      last_t = $realtime;
   end
endmodule : ocf_clk_sink

//--- verification/ocf_top_tb.sv
`timescale 1ns/100ps
module ocf_top_tb;
   import ocf_pkg::*;
   logic clock = '0, sys_rst = '1, reg_wr = '0, reg_rd = '0, scan_data_in = '1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [3:0] dpll_tick = 4'h0;
   logic [2:0] loop_mode = 3'h5;
   logic [1:0] ref_select = 2'h0;
   logic apll_main_tick = '0, apll_aux_tick = '0, ev_ref_valid_change = '0;
   logic ev_ref_fail = '0, ev_mode_change = '0, ext_frame_in_a = '1;
   logic ext_frame_in_b = '1, ext_frame_in_c = '1, clkout_a, clkout_b;
   logic clkout_a_lvds_select, frame_sync_pin, frame_sync_pin_oe;
   logic multiframe_sync_pin, multiframe_sync_pin_oe, irq_pin;
   logic irq_pin_oe, scan_out;
   int err_total = 0, checks_done = 0, cyc = 0, per_a, per_f;
   // Offset, write data, expected read back
   logic [23:0] rows [9] = '{24'h710f0f, 24'h6d4141, 24'h74c0c0,
      24'h120202, 24'h0b0101, 24'h0c0000, 24'h205500, 24'h52ff05,
      24'h0a0101};
   ocf_top #(.FRAME_CYCLES(50), .FS8_HALF_TICKS(8)) i_dut (.*);
   ocf_clk_sink i_sink_a (.clk_in(clkout_a), .period_ns(per_a));
   ocf_clk_sink i_sink_f (.clk_in(frame_sync_pin), .period_ns(per_f));
   always #5 clock = ~clock;
   task automatic chk(input string nm, input logic [15:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      @(posedge clock);
      #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
      @(posedge clock);
      #1 reg_wr = '0;
   endtask : wr
   task automatic rchk(input string nm, input logic [7:0] a, exp);
      @(posedge clock);
      #1 {reg_addr, reg_rd} = {a, 1'h1};
      @(posedge clock);
      #1 reg_rd = '0;
      chk(nm, reg_rdata, exp);
   endtask : rchk
   task automatic stop_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   // Ceiling on run length
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         stop_test();
      end
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clock);
      #1 sys_rst = '0;
      rchk("freq_a", OCF_ADDR_CLKOUT_A_FREQ, OCF_CFG_RESET);
      chk("scan_idle_irq", {scan_out, irq_pin, irq_pin_oe}, 16'h7);
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rchk("reg", rows[i][23:16], rows[i][7:0]);
      end
      chk("clk_a_oe", {clkout_a, multiframe_sync_pin_oe}, 16'h3);
      chk("lvds_sel", clkout_a_lvds_select, 16'h1);
      // Three events at once, only failure enabled
      @(posedge clock);
      #1 {ev_ref_valid_change, ev_ref_fail, ev_mode_change} = 3'h7;
      @(posedge clock);
      #1 {ev_ref_valid_change, ev_ref_fail, ev_mode_change} = 3'h0;
      @(posedge clock);
      #1 chk("irq_on", {irq_pin, scan_out}, 16'h1);
      rchk("status", OCF_ADDR_IRQ_STATUS_G3, 8'h07);
      wr(OCF_ADDR_IRQ_PIN_CONFIG, 8'h02);
      wr(OCF_ADDR_IRQ_STATUS_G3, 8'h02);
      repeat (2) @(posedge clock);
      #1 chk("irq_off", {irq_pin_oe, scan_out}, 16'h0);
      rchk("status_clr", OCF_ADDR_IRQ_STATUS_G3, 8'h05);
      // Aux loop code 3 divides by 8 per period; output B inverted
      wr(OCF_ADDR_CLKOUT_B_FREQ, 8'h53);
      wr(OCF_ADDR_CLKOUT_B_INV, 8'h01);
      wr(OCF_ADDR_CLKOUT_A_FREQ, 8'h53);
      {apll_aux_tick, apll_main_tick} = 2'h3;
      repeat (60) @(posedge clock);
      #1 chk("period_a", per_a[15:0], 16'h50);
      chk("period_fs", per_f[15:0], 16'ha0);
      chk("clk_ab", {clkout_a, clkout_b}, 16'h1);
      chk("fs_lvl", {frame_sync_pin, multiframe_sync_pin}, 16'h3);
      {apll_aux_tick, apll_main_tick} = 2'h0;
      wr(OCF_ADDR_CLKOUT_A_FREQ, 8'h59);
      repeat (4) @(posedge clock);
      #1 chk("aux_obsai", clkout_a, 16'h0);
      // Late falling edge on sync input A raises the alarm
      ext_frame_in_a = '0;
      repeat (8) @(posedge clock);
      rchk("alarm_live", OCF_ADDR_OPERATING_STATE, 8'h85);
      rchk("alarm_event", OCF_ADDR_IRQ_STATUS_G3, 8'h0d);
      stop_test();
   end
endmodule : ocf_top_tb
